// [verilog/oc_chan_cfg.svh]
// register map, field positions and reset values of the compare channel
// assumes a 32-bit apb data path with word aligned registers
`ifndef OC_CHAN_CFG_SVH
`define OC_CHAN_CFG_SVH

`define OC_ADDR_W 12
`define OC_CTRL_OFS 12'h000
`define OC_PRIMARY_OFS 12'h004
`define OC_DUTY_OFS 12'h008

`define OC_IDLE_STOP_BIT 13
`define OC_FAULT_BIT 4
`define OC_TSEL_BIT 3
`define OC_MODE_MSB 2
`define OC_MODE_LSB 0

`define OC_CTRL_RST 1'b0
`define OC_CMP_RST 16'h0000
`define OC_RDATA_RST 32'h0000_0000

`endif

// [verilog/oc_chan_pkg.sv]
// types shared by the compare channel modules
// assumes nothing beyond a systemverilog compiler
package oc_chan_pkg;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_SET_HIGH = 3'h1,
    MODE_FORCE_LOW = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_ONE_PULSE = 3'h4,
    MODE_PULSES = 3'h5,
    MODE_PWM = 3'h6,
    MODE_PWM_FAULT = 3'h7
  } mode_t;

  typedef enum logic [2:0] {
    PS_WAIT = 3'b001,
    PS_HIGH = 3'b010,
    PS_DONE = 3'b100
  } pulse_state_t;

endpackage

// [verilog/timebase_select.sv]
// picks one of two shared timers and forms the three compare matches
// assumes both timers count up and wrap on their own period match
`timescale 1ns/1ns
`default_nettype none

module timebase_select #(
  parameter int CNT_W = 16
) (
  input wire logic sel_b,
  input wire logic [CNT_W-1:0] count_a,
  input wire logic [CNT_W-1:0] period_a,
  input wire logic [CNT_W-1:0] count_b,
  input wire logic [CNT_W-1:0] period_b,
  input wire logic [CNT_W-1:0] primary,
  input wire logic [CNT_W-1:0] secondary,
  output logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] period,
  output logic period_match,
  output logic primary_match,
  output logic secondary_match
);

  assign count = sel_b ? count_b : count_a;
  assign period = sel_b ? period_b : period_a;
  assign period_match = (count == period);
  assign primary_match = (count == primary);
  assign secondary_match = (count == secondary);

endmodule

`default_nettype wire

// [verilog/duty_shadow.sv]
// active compare value: written by software, or reloaded from the duty buffer
// load and software write are both qualified here by the ce input, load winning over a write
`timescale 1ns/1ns
`default_nettype none

module duty_shadow #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic pwm_mode,
  input wire logic load,
  input wire logic sw_we,
  input wire logic [CNT_W-1:0] sw_data,
  input wire logic [CNT_W-1:0] duty,
  output logic [CNT_W-1:0] active_ff
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff <= '0;
    end else if (ce) begin
      if (load) begin
        active_ff <= duty;
      end else if (sw_we && !pwm_mode) begin
        active_ff <= sw_data;
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/output_compare_pwm_channel.sv]
// output compare / pwm channel with apb register access
// assumes two shared up-counting timers and a fault pin shared with a sibling channel
//
// Behaviour
// - pwm period is timer period value plus one count cycles
// - duty buffer copies into primary compare only at timer period match
// - primary compare is read-only while a pwm mode is selected
// - pwm with active duty zero keeps output low whole period
// - pwm with active duty above period keeps output high always
// - pwm with duty equal to period gives one low count per period
// - idle stop bit one halts channel during cpu idle
// - fault flag reads one after pwm fault, cleared by hardware only
// - timebase select one picks timer b, zero picks timer a
// - mode 111 is pwm with fault, 110 pwm without fault
// - mode 101 starts low then pulses on every match pair
// - mode 100 starts low then gives exactly one pulse
// - mode 011 toggles output on each compare match
// - mode 010 starts high, compare match forces low
// - mode 001 starts low, compare match forces high
// - mode 000 disables channel, output unaffected by compares
// - one shared fault input serves first and second channels
// - control bits 15-14 and 12-5 read as zero
// - single pulse mode holds output low after trailing edge
// - continuous pulse mode flags event on each secondary match that ends a pulse
`timescale 1ns/1ns
`default_nettype none
`include "oc_chan_cfg.svh"

module output_compare_pwm_channel #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`OC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CNT_W-1:0] timebase_a_count,
  input wire logic [CNT_W-1:0] timebase_a_period,
  input wire logic [CNT_W-1:0] timebase_b_count,
  input wire logic [CNT_W-1:0] timebase_b_period,
  input wire logic cpu_idle,
  input wire logic shared_fault_input_n,
  output logic compare_output_pin,
  output logic compare_irq_flag
);
  import oc_chan_pkg::*;

  generate
    if (CNT_W < 2 || CNT_W > 16) begin : bad_cnt_w
      $error("CNT_W must lie between 2 and 16");
    end
  endgenerate

  logic idle_stop_ff;
  logic tsel_ff;
  logic fault_flag_ff;
  mode_t mode_ff;
  pulse_state_t ps_ff;
  pulse_state_t nxt_ps;
  logic [CNT_W-1:0] duty_ff;
  logic [CNT_W-1:0] active_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic pin_ff;
  logic irq_ff;
  logic nxt_irq;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] period;
  logic period_match;
  logic pri_match;
  logic sec_match;
  logic setup;
  logic wr_en;
  logic hit_ctrl;
  logic hit_pri;
  logic hit_duty;
  logic mode_wr;
  logic pri_wr;
  logic run;
  logic pwm_mode;
  logic fault_now;
  logic [15:0] ctrl_rd;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign compare_output_pin = pin_ff;
  assign compare_irq_flag = irq_ff;

  // apb decode; a write lands only on the completing access edge
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign hit_ctrl = (paddr == `OC_CTRL_OFS);
  assign hit_pri = (paddr == `OC_PRIMARY_OFS);
  assign hit_duty = (paddr == `OC_DUTY_OFS);
  assign mode_wr = wr_en && hit_ctrl;
  assign pri_wr = wr_en && hit_pri;

  // frozen while idle stop is set and the cpu idles
  assign run = ce && !(idle_stop_ff && cpu_idle);
  assign pwm_mode = (mode_ff == MODE_PWM) || (mode_ff == MODE_PWM_FAULT);
  // the pin is shared with the sibling channel; only mode 111 listens
  assign fault_now = (mode_ff == MODE_PWM_FAULT) && !shared_fault_input_n;

  timebase_select #(
    .CNT_W(CNT_W)
  ) u_tb (
    .sel_b(tsel_ff),
    .count_a(timebase_a_count),
    .period_a(timebase_a_period),
    .count_b(timebase_b_count),
    .period_b(timebase_b_period),
    .primary(active_ff),
    .secondary(duty_ff),
    .count(count),
    .period(period),
    .period_match(period_match),
    .primary_match(pri_match),
    .secondary_match(sec_match)
  );

  duty_shadow #(
    .CNT_W(CNT_W)
  ) u_shadow (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pwm_mode(pwm_mode),
    .load(run && pwm_mode && period_match && !mode_wr),
    .sw_we(pri_wr),
    .sw_data(pwdata[CNT_W-1:0]),
    .duty(duty_ff),
    .active_ff(active_ff)
  );

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[`OC_IDLE_STOP_BIT] = idle_stop_ff;
    ctrl_rd[`OC_FAULT_BIT] = fault_flag_ff;
    ctrl_rd[`OC_TSEL_BIT] = tsel_ff;
    ctrl_rd[`OC_MODE_MSB:`OC_MODE_LSB] = mode_ff;
  end

  // bus answer: read data, error and ready all register at the end of setup and show in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= `OC_RDATA_RST;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= setup;
      pslverr_ff <= setup && !(hit_ctrl || hit_pri || hit_duty);
      if (setup && !pwrite) begin
        if (hit_ctrl) begin
          prdata_ff <= {16'h0000, ctrl_rd};
        end else if (hit_pri) begin
          prdata_ff <= {{(32-CNT_W){1'b0}}, active_ff};
        end else if (hit_duty) begin
          prdata_ff <= {{(32-CNT_W){1'b0}}, duty_ff};
        end else begin
          prdata_ff <= `OC_RDATA_RST;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_stop_ff <= `OC_CTRL_RST;
      tsel_ff <= `OC_CTRL_RST;
      mode_ff <= MODE_OFF;
    end else if (ce && mode_wr) begin
      idle_stop_ff <= pwdata[`OC_IDLE_STOP_BIT];
      tsel_ff <= pwdata[`OC_TSEL_BIT];
      mode_ff <= mode_t'(pwdata[`OC_MODE_MSB:`OC_MODE_LSB]);
    end
  end

  // duty buffer accepts software writes in every mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_ff <= CNT_W'(`OC_CMP_RST);
    end else if (ce && wr_en && hit_duty) begin
      duty_ff <= pwdata[CNT_W-1:0];
    end
  end

  // set wins over the hardware clear done by a mode rewrite
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flag_ff <= `OC_CTRL_RST;
    end else if (ce) begin
      if (run && fault_now) begin
        fault_flag_ff <= 1'b1;
      end else if (mode_wr) begin
        fault_flag_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_ps = ps_ff;
    case (ps_ff)
      PS_WAIT: begin
        if (pri_match) begin
          nxt_ps = PS_HIGH;
        end
      end
      PS_HIGH: begin
        if (sec_match) begin
          nxt_ps = (mode_ff == MODE_PULSES) ? PS_WAIT : PS_DONE;
        end
      end
      PS_DONE: nxt_ps = PS_DONE;
      default: nxt_ps = PS_WAIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_ff <= PS_WAIT;
    end else if (ce) begin
      if (mode_wr) begin
        ps_ff <= PS_WAIT;
      end else if (run && (mode_ff == MODE_ONE_PULSE || mode_ff == MODE_PULSES)) begin
        ps_ff <= nxt_ps;
      end
    end
  end

  // pwm output is one clock behind the count it was judged on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= 1'b0;
    end else if (ce) begin
      if (mode_wr) begin
        pin_ff <= (pwdata[`OC_MODE_MSB:`OC_MODE_LSB] == MODE_FORCE_LOW);
      end else if (run) begin
        case (mode_ff)
          MODE_OFF: pin_ff <= pin_ff;
          MODE_SET_HIGH: begin
            if (pri_match) begin
              pin_ff <= 1'b1;
            end
          end
          MODE_FORCE_LOW: begin
            if (pri_match) begin
              pin_ff <= 1'b0;
            end
          end
          MODE_TOGGLE: begin
            if (pri_match) begin
              pin_ff <= !pin_ff;
            end
          end
          MODE_ONE_PULSE, MODE_PULSES: begin
            if (ps_ff == PS_WAIT && pri_match) begin
              pin_ff <= 1'b1;
            end else if (ps_ff != PS_WAIT && nxt_ps != PS_HIGH) begin
              pin_ff <= 1'b0;
            end
          end
          MODE_PWM, MODE_PWM_FAULT: begin
            if (fault_now || fault_flag_ff) begin
              pin_ff <= 1'b0;
            end else begin
              // count runs 0..period, so period+1 slots per cycle
              pin_ff <= (count < active_ff);
            end
          end
          default: pin_ff <= pin_ff;
        endcase
      end
    end
  end

  always_comb begin
    nxt_irq = 1'b0;
    if (run && !mode_wr) begin
      case (mode_ff)
        MODE_OFF: nxt_irq = 1'b0;
        MODE_SET_HIGH, MODE_FORCE_LOW, MODE_TOGGLE: nxt_irq = pri_match;
        MODE_ONE_PULSE, MODE_PULSES: nxt_irq = (ps_ff == PS_HIGH) && sec_match;
        MODE_PWM, MODE_PWM_FAULT: nxt_irq = period_match || (fault_now && !fault_flag_ff);
        default: nxt_irq = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= nxt_irq;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic steady;
  assign steady = run && !mode_wr;

  sequence pulse_rise_s;
    steady && mode_ff == MODE_ONE_PULSE && ps_ff == PS_WAIT && pri_match && !sec_match;
  endsequence
  sequence pulse_fall_s;
    steady && mode_ff == MODE_ONE_PULSE && ps_ff == PS_HIGH && sec_match;
  endsequence

  pwm_zero_low_a: assert property (steady && pwm_mode && active_ff == '0 |=> !pin_ff)
    else $error("pwm output high with zero duty");
  pwm_full_high_a: assert property (steady && pwm_mode && !fault_flag_ff && !fault_now
      && active_ff > period && count <= period |=> pin_ff)
    else $error("pwm output low with duty above period");
  pwm_equal_low_a: assert property (steady && pwm_mode && !fault_flag_ff && !fault_now
      && active_ff == period && period_match |=> !pin_ff)
    else $error("pwm output not low at period count with duty equal period");
  duty_load_a: assert property (steady && pwm_mode && period_match |=> active_ff == $past(duty_ff))
    else $error("duty buffer not copied at period match");
  primary_ro_a: assert property (ce && pri_wr && pwm_mode && !(run && period_match)
      |=> $stable(active_ff))
    else $error("primary compare written in pwm mode");
  reserved_zero_a: assert property (ce && setup && !pwrite && hit_ctrl
      |=> prdata_ff[15:14] == 2'b00 && prdata_ff[12:5] == 8'h00)
    else $error("reserved control bits read non-zero");
  fault_force_a: assert property (steady && fault_now |=> fault_flag_ff && !pin_ff)
    else $error("fault did not set flag and force output low");
  idle_halt_a: assert property (ce && idle_stop_ff && cpu_idle && !mode_wr
      |=> $stable(pin_ff) && !irq_ff)
    else $error("channel active during idle with stop set");
  toggle_pin_a: assert property (steady && mode_ff == MODE_TOGGLE && pri_match
      |=> pin_ff != $past(pin_ff))
    else $error("compare match did not toggle output");
  one_pulse_a: assert property (pulse_rise_s |=> pin_ff && ps_ff == PS_HIGH)
    else $error("single pulse sequence broken");
  pulse_done_a: assert property (pulse_fall_s |=> !pin_ff && ps_ff == PS_DONE)
    else $error("single pulse did not end low");
  pulses_irq_a: assert property (steady && mode_ff == MODE_PULSES && ps_ff == PS_HIGH
      && sec_match |=> irq_ff && ps_ff == PS_WAIT)
    else $error("secondary match in continuous pulses raised no event");
  force_high_a: assert property (steady && mode_ff == MODE_SET_HIGH && pri_match |=> pin_ff)
    else $error("compare match did not force output high");
  disabled_a: assert property (steady && mode_ff == MODE_OFF |=> $stable(pin_ff) && !irq_ff)
    else $error("disabled channel changed output");

endmodule

`default_nettype wire

// [tb/timer_pair.sv]
// two free running up-counters standing in for the shared timers
// assumes one clock; run low freezes both counts for setup windows
`timescale 1ns/1ns
`default_nettype none

module timer_pair #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [W-1:0] per_a,
  input wire logic [W-1:0] per_b,
  output logic [W-1:0] cnt_a,
  output logic [W-1:0] cnt_b
);
  // wrap on period match gives a period of per + 1 counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a <= '0;
      cnt_b <= '0;
    end else if (run) begin
      cnt_a <= (cnt_a == per_a) ? '0 : cnt_a + 1'b1;
      cnt_b <= (cnt_b == per_b) ? '0 : cnt_b + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the compare channel, apb master tasks
// assumes timer_pair as time base, fault pin idle high
`timescale 1ns/1ns
`default_nettype none
`include "oc_chan_cfg.svh"

module testbench;
  logic pclk, presetn, ce, psel, penable, pwrite, cpu_idle, fault_n, run;
  logic [`OC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, pin, irq, last;
  logic [15:0] ca, cb, pa, pb;
  int mismatches, checks_done, cyc, hi, nirq, tg;
  int dv[5] = '{0, 7, 8, 9, 3};
  // packed hi, irq and toggle counts over a steady 16 cycle window
  logic [31:0] mexp[6] = '{32'h0, 32'h1020, 32'h020, 32'h822, 32'h0, 32'h624};

  output_compare_pwm_channel DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timebase_a_count(ca),
    .timebase_a_period(pa), .timebase_b_count(cb), .timebase_b_period(pb),
    .cpu_idle(cpu_idle), .shared_fault_input_n(fault_n),
    .compare_output_pin(pin), .compare_irq_flag(irq));

  timer_pair timers (.clk(pclk), .rst_n(presetn), .run(run), .per_a(pa),
    .per_b(pb), .cnt_a(ca), .cnt_b(cb));

  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  task end_sim;
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // whole run needs about 750 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [`OC_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [`OC_ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [`OC_ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task meas(input int n);
    hi = 0;
    nirq = 0;
    tg = 0;
    last = pin;
    repeat (n) begin
      @(posedge pclk);
      #1;
      if (pin !== last) tg++;
      last = pin;
      hi += (pin === 1'b1);
      nirq += (irq === 1'b1);
    end
  endtask

  // freeze timer a just past zero, away from every match
  task halt;
    do @(posedge pclk); while (ca !== 16'h0);
    run <= 0;
  endtask

  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; ce = 1;
    cpu_idle = 0; fault_n = 1; run = 1; pa = 16'h7; pb = 16'hf; presetn = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rdc(`OC_CTRL_OFS, 0);
    rdc(`OC_PRIMARY_OFS, 0);
    rdc(`OC_DUTY_OFS, 0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    wr(`OC_CTRL_OFS, 32'hffff);
    rdc(`OC_CTRL_OFS, 32'h200f);
    wr(`OC_CTRL_OFS, 0);
    wr(`OC_PRIMARY_OFS, 3);
    wr(`OC_DUTY_OFS, 3);
    wr(`OC_CTRL_OFS, 6);
    meas(24);
    meas(8);
    chk(hi, 3);
    foreach (dv[i]) begin
      wr(`OC_DUTY_OFS, dv[i]);
      meas(24);
      meas(8);
      chk(hi, (dv[i] > 8) ? 8 : dv[i]);
      rdc(`OC_PRIMARY_OFS, dv[i]);
    end
    wr(`OC_PRIMARY_OFS, 5);
    rdc(`OC_PRIMARY_OFS, 3);
    halt();
    wr(`OC_DUTY_OFS, 1);
    rdc(`OC_PRIMARY_OFS, 3);
    run <= 1;
    meas(24);
    rdc(`OC_PRIMARY_OFS, 1);
    meas(8);
    chk(hi, 1);
    wr(`OC_CTRL_OFS, 32'he);
    meas(40);
    meas(16);
    chk(hi, 1);
    wr(`OC_CTRL_OFS, 6);
    fault_n <= 0;
    meas(8);
    chk(hi, 1);
    @(posedge pclk);
    fault_n <= 1;
    wr(`OC_CTRL_OFS, 7);
    fault_n <= 0;
    @(posedge pclk);
    #1;
    chk(irq, 1);
    meas(2);
    @(posedge pclk);
    fault_n <= 1;
    rdc(`OC_CTRL_OFS, 32'h17);
    meas(16);
    chk(hi, 0);
    wr(`OC_CTRL_OFS, 7);
    rdc(`OC_CTRL_OFS, 7);
    wr(`OC_CTRL_OFS, 0);
    wr(`OC_PRIMARY_OFS, 2);
    wr(`OC_DUTY_OFS, 5);
    for (int m = 0; m < 6; m++) begin
      halt();
      wr(`OC_CTRL_OFS, m);
      meas(2);
      chk(pin, m == 2);
      @(posedge pclk);
      run <= 1;
      meas(16);
      if (m == 4) chk(hi, 3);
      meas(16);
      chk(hi * 256 + nirq * 16 + tg, mexp[m]);
    end
    for (int k = 0; k < 2; k++) begin
      wr(`OC_CTRL_OFS, k ? 32'h2003 : 32'h3);
      @(posedge pclk);
      cpu_idle <= 1;
      meas(16);
      chk(tg, k ? 0 : 2);
      @(posedge pclk);
      cpu_idle <= 0;
    end
    // clock enable low must freeze the toggling pin like idle stop does
    ce <= 0;
    meas(16);
    chk(tg, 0);
    ce <= 1;
    end_sim();
  end
endmodule
`default_nettype wire
